/* rtl/gpio_group0_jtag_port.sv */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "gpio_group0_cfg.svh"
module gpio_group0_jtag_port
  import gpio_group0_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // further reset sources
  input wire logic i_wdt_overflow,
  input wire logic i_external_reset_pin,
  // power state
  input wire logic i_sleep,
  input wire logic i_deep_sleep,
  // register port
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // pads
  input wire logic i_debug_select_pin,
  input wire logic [3:0] i_pad_i,
  output logic [3:0] o_pad_o,
  output logic [3:0] o_pad_oe,
  output logic [3:0] o_pad_ie,
  // jtag core side
  input wire logic i_jtag_tdo,
  output logic o_jtag_tdi,
  output logic o_jtag_tms,
  output logic o_jtag_tck,
  // power gates and wake
  output logic o_low_groups_gate,
  output logic o_group9_gate,
  output logic o_group10_gate,
  output logic o_wake
);

  ////////////////////////////////////////////////////////////////////////////
  // reset and pin synchronisation

  logic ext_rst_sync;
  logic debug_sel_sync;
  logic debug_sel_n_sync;
  logic [3:0] pad_sync;
  logic rst_all;
  logic asleep;

  sync2 #(.WIDTH(1)) u_sync_rst (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async(i_external_reset_pin),
    .o_sync(ext_rst_sync)
  );

  sync2 #(.WIDTH(5)) u_sync_pads (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({~i_debug_select_pin, i_pad_i}),
    .o_sync({debug_sel_n_sync, pad_sync})
  );

  // carried inverted so the cleared synchroniser means gpio, the pin's idle level;
  // otherwise the pads would flash into jtag directions just after reset
  assign debug_sel_sync = ~debug_sel_n_sync;

  // reset pin is active high here once synced; watchdog comes from our own clock
  assign rst_all = i_rst | i_wdt_overflow | ext_rst_sync;
  assign asleep = i_sleep | i_deep_sleep;

  ////////////////////////////////////////////////////////////////////////////
  // register file

  nibble_t out_enable_n_reg;
  nibble_t in_enable_reg;
  nibble_t out_data_reg;
  nibble_t in_data_reg;
  logic [7:0] power_control_reg;
  logic [7:0] wake_control_reg;
  logic [7:0] rdata_next;

  function automatic logic wr_hit(input logic [15:0] addr, input logic [15:0] target);
    wr_hit = (addr == target);
  endfunction

  // writes are dropped while asleep so the pads keep their state
  logic wr_ok;
  assign wr_ok = i_wr & ~asleep;

  always_ff @(posedge i_mclk)
  begin
    if (rst_all)
      out_enable_n_reg <= `OUT_ENABLE_RST;
    else if (wr_ok && wr_hit(i_addr, `ADDR_OUT_ENABLE))
      out_enable_n_reg <= i_wdata[3:0];
  end

  always_ff @(posedge i_mclk)
  begin
    if (rst_all)
      in_enable_reg <= `IN_ENABLE_RST;
    else if (wr_ok && wr_hit(i_addr, `ADDR_IN_ENABLE))
      in_enable_reg <= i_wdata[3:0];
  end

  always_ff @(posedge i_mclk)
  begin
    if (rst_all)
      out_data_reg <= `OUT_DATA_RST;
    else if (wr_ok && wr_hit(i_addr, `ADDR_OUT_DATA))
      out_data_reg <= i_wdata[3:0];
  end

  always_ff @(posedge i_mclk)
  begin
    if (rst_all)
      power_control_reg <= `POWER_CONTROL_RST;
    else if (wr_ok && wr_hit(i_addr, `ADDR_PORT_POWER_CONTROL))
      power_control_reg <= i_wdata;
  end

  always_ff @(posedge i_mclk)
  begin
    if (rst_all)
      wake_control_reg <= `WAKE_CONTROL_RST;
    else if (wr_ok && wr_hit(i_addr, `ADDR_IO_WAKE_CONTROL))
      wake_control_reg <= i_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad mode

  pad_mode_t mode;
  logic low_groups_gate;

  assign low_groups_gate = power_control_reg[`LOW_GROUPS_GATE_BIT];

  always_comb
  begin
    // jtag is not affected by the gate, like other special functions
    if (!debug_sel_sync)
      mode = MODE_JTAG;
    else if (low_groups_gate)
      mode = MODE_GATED;
    else
      mode = MODE_GPIO;
  end

  // group gates go out as register levels; this block only owns group zero
  assign o_low_groups_gate = low_groups_gate;
  assign o_group9_gate = power_control_reg[`GROUP9_GATE_BIT];
  assign o_group10_gate = power_control_reg[`GROUP10_GATE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // pad driver

  pad_ctrl_if pads ();

  assign pads.mode = mode;
  assign pads.out_enable_n = out_enable_n_reg;
  assign pads.in_enable = in_enable_reg;
  assign pads.out_data = out_data_reg;
  assign pads.tdo = i_jtag_tdo;

  pad_mux u_pad_mux (
    .i_mclk(i_mclk),
    .i_rst(rst_all),
    .ctl(pads)
  );

  assign o_pad_o = pads.pad_o;
  assign o_pad_oe = pads.pad_oe;
  assign o_pad_ie = pads.pad_ie;

  ////////////////////////////////////////////////////////////////////////////
  // jtag inputs

  logic tdi_reg;
  logic tms_reg;
  logic tck_reg;

  // outside debug mode the jtag inputs rest low
  always_ff @(posedge i_mclk)
  begin
    if (rst_all)
    begin
      tdi_reg <= 1'b0;
      tms_reg <= 1'b0;
      tck_reg <= 1'b0;
    end
    else if (mode == MODE_JTAG)
    begin
      tdi_reg <= pad_sync[`JTAG_TDI_BIT];
      tms_reg <= pad_sync[`JTAG_TMS_BIT];
      tck_reg <= pad_sync[`JTAG_TCK_BIT];
    end
    else
    begin
      tdi_reg <= 1'b0;
      tms_reg <= 1'b0;
      tck_reg <= 1'b0;
    end
  end

  assign o_jtag_tdi = tdi_reg;
  assign o_jtag_tms = tms_reg;
  assign o_jtag_tck = tck_reg;

  ////////////////////////////////////////////////////////////////////////////
  // input data

  // disabled inputs read zero; the register toggles with the pins, which costs power
  always_ff @(posedge i_mclk)
  begin
    if (rst_all)
      in_data_reg <= `IN_DATA_RST;
    else if (!asleep && mode == MODE_GPIO)
      in_data_reg <= pad_sync & in_enable_reg;
    else if (!asleep)
      in_data_reg <= `IN_DATA_RST;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake detection

  logic [1:0] wake_prev_reg;
  logic [1:0] wake_pins;
  logic [1:0] wake_armed;
  logic wake_reg;

  assign wake_pins = pad_sync[`WAKE_BIT_HI:`WAKE_BIT_LO];
  assign wake_armed = in_enable_reg[`WAKE_BIT_HI:`WAKE_BIT_LO]
                      & {2{wake_control_reg[`GROUP0_WAKE_SELECT_BIT]}};

  always_ff @(posedge i_mclk)
  begin
    if (rst_all)
      wake_prev_reg <= 2'h0;
    else
      wake_prev_reg <= wake_pins;
  end

  // either edge on an armed pin wakes; only in gpio mode and only while asleep
  always_ff @(posedge i_mclk)
  begin
    if (rst_all)
      wake_reg <= 1'b0;
    else
      wake_reg <= asleep && mode == MODE_GPIO && |((wake_pins ^ wake_prev_reg) & wake_armed);
  end

  assign o_wake = wake_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read back

  always_comb
  begin
    rdata_next = 8'h00;
    if (i_rd)
    begin
      case (i_addr)
        `ADDR_OUT_ENABLE: rdata_next = {4'h0, out_enable_n_reg};
        `ADDR_IN_ENABLE: rdata_next = {4'h0, in_enable_reg};
        `ADDR_OUT_DATA: rdata_next = {4'h0, out_data_reg};
        `ADDR_IN_DATA: rdata_next = {4'h0, in_data_reg};
        `ADDR_PORT_POWER_CONTROL: rdata_next = power_control_reg;
        `ADDR_IO_WAKE_CONTROL: rdata_next = wake_control_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // data valid only in the cycle after the read strobe
  always_ff @(posedge i_mclk)
  begin
    if (rst_all)
      o_rdata <= 8'h00;
    else
      o_rdata <= rdata_next;
  end

endmodule

/* rtl/gpio_group0_cfg.svh */
`ifndef GPIO_GROUP0_CFG_SVH
`define GPIO_GROUP0_CFG_SVH

// register byte addresses
`define ADDR_OUT_ENABLE 16'h28a8
`define ADDR_IN_ENABLE 16'h28a9
`define ADDR_OUT_DATA 16'h28aa
`define ADDR_IN_DATA 16'h28ab
`define ADDR_PORT_POWER_CONTROL 16'h2d00
`define ADDR_IO_WAKE_CONTROL 16'h00c9

// field positions
`define LOW_GROUPS_GATE_BIT 3
`define GROUP9_GATE_BIT 4
`define GROUP10_GATE_BIT 5
`define GROUP0_WAKE_SELECT_BIT 1
`define WAKE_BIT_LO 2
`define WAKE_BIT_HI 3

// bit roles in debug mode
`define JTAG_TDO_BIT 0
`define JTAG_TDI_BIT 1
`define JTAG_TMS_BIT 2
`define JTAG_TCK_BIT 3

// reset values
`define OUT_ENABLE_RST 4'hf
`define IN_ENABLE_RST 4'h0
`define OUT_DATA_RST 4'hf
`define IN_DATA_RST 4'h0
`define POWER_CONTROL_RST 8'h00
`define WAKE_CONTROL_RST 8'h00

// synchroniser depth
`define SYNC_STAGES 2

`endif

/* rtl/gpio_group0_pkg.sv */
package gpio_group0_pkg;

  // what the four pads are doing this cycle
  typedef enum logic [1:0] {
    MODE_JTAG,
    MODE_GPIO,
    MODE_GATED
  } pad_mode_t;

  typedef logic [3:0] nibble_t;

endpackage

/* rtl/pad_ctrl_if.sv */
`timescale 1ns/1ps
interface pad_ctrl_if;
  import gpio_group0_pkg::*;
  pad_mode_t mode;
  nibble_t out_enable_n;
  nibble_t in_enable;
  nibble_t out_data;
  logic tdo;
  nibble_t pad_o;
  nibble_t pad_oe;
  nibble_t pad_ie;

  modport ctrl (output mode, output out_enable_n, output in_enable, output out_data, output tdo,
                input pad_o, input pad_oe, input pad_ie);
  modport mux (input mode, input out_enable_n, input in_enable, input out_data, input tdo,
               output pad_o, output pad_oe, output pad_ie);
endinterface

/* rtl/sync2.sv */
`timescale 1ns/1ps
`include "gpio_group0_cfg.svh"
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // async level in, synced level out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      meta_reg <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

/* rtl/pad_mux.sv */
`timescale 1ns/1ps
`include "gpio_group0_cfg.svh"
module pad_mux
  import gpio_group0_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // control from the register block
  pad_ctrl_if.mux ctl
);
  nibble_t o_next;
  nibble_t oe_next;
  nibble_t ie_next;

  always_comb
  begin
    o_next = ctl.out_data;
    oe_next = ~ctl.out_enable_n;
    ie_next = ctl.in_enable;
    case (ctl.mode)
      MODE_JTAG:
      begin
        // tdo out on bit 0, other three are jtag inputs
        o_next = 4'h0;
        o_next[`JTAG_TDO_BIT] = ctl.tdo;
        oe_next = 4'h0;
        oe_next[`JTAG_TDO_BIT] = 1'b1;
        ie_next = 4'hf;
        ie_next[`JTAG_TDO_BIT] = 1'b0;
      end
      MODE_GPIO:
      begin
        o_next = ctl.out_data;
        oe_next = ~ctl.out_enable_n;
        ie_next = ctl.in_enable;
      end
      MODE_GATED:
      begin
        // gated: driver and input buffer both off to save power
        o_next = 4'h0;
        oe_next = 4'h0;
        ie_next = 4'h0;
      end
      default:
      begin
        o_next = 4'h0;
        oe_next = 4'h0;
        ie_next = 4'h0;
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      ctl.pad_o <= 4'h0;
      ctl.pad_oe <= 4'h0;
      ctl.pad_ie <= 4'h0;
    end
    else
    begin
      ctl.pad_o <= o_next;
      ctl.pad_oe <= oe_next;
      ctl.pad_ie <= ie_next;
    end
  end
endmodule

/* verif/gpio_group0_assertions.sv */
`timescale 1ns/1ps
`include "gpio_group0_cfg.svh"
module gpio_group0_assertions (
  // clock and resets
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_wdt_overflow,
  input wire logic i_external_reset_pin,
  // power and register port
  input wire logic i_sleep,
  input wire logic i_deep_sleep,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // pads and jtag
  input wire logic i_debug_select_pin,
  input wire logic [3:0] i_pad_i,
  input wire logic [3:0] o_pad_o,
  input wire logic [3:0] o_pad_oe,
  input wire logic [3:0] o_pad_ie,
  input wire logic i_jtag_tdo,
  input wire logic o_jtag_tdi,
  input wire logic o_jtag_tms,
  input wire logic o_jtag_tck,
  // gates
  input wire logic o_low_groups_gate,
  input wire logic o_group9_gate,
  input wire logic o_group10_gate
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst || i_wdt_overflow);
  logic [2:0] gpio_cnt_reg;
  wire awake = !i_sleep && !i_deep_sleep;
  wire gpio_ok = gpio_cnt_reg == 3'h7;
  // the mode pin crosses a synchroniser, so wait out its latency before judging pads
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || i_wdt_overflow || i_external_reset_pin || !i_debug_select_pin)
      gpio_cnt_reg <= 3'h0;
    else if (!gpio_ok)
      gpio_cnt_reg <= gpio_cnt_reg + 3'h1;
  end
  ////////////////////////////////////////////////////////////
  sequence s_jtag;
    (!i_debug_select_pin && !i_external_reset_pin)[*8];
  endsequence
  sequence s_pins_still;
    ($stable(i_pad_i))[*8];
  endsequence
  property p_reset_off;
    $past(i_rst) |-> o_pad_oe == 4'h0 && o_pad_ie == 4'h0 && !o_low_groups_gate && o_rdata == 8'h00;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("pads or gate not off after reset");
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_oe_write;
    gpio_ok && awake && !o_low_groups_gate && i_wr && i_addr == `ADDR_OUT_ENABLE
      |-> ##2 o_pad_oe == ~$past(i_wdata[3:0], 2);
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("pad drive not from enable bits");
  property p_gated;
    gpio_ok && o_low_groups_gate && $past(o_low_groups_gate) |-> (o_pad_oe | o_pad_ie) == 4'h0;
  endproperty
  a_gated: assert property (p_gated) else $error("gated pads still active");
  property p_power_write;
    awake && i_wr && i_addr == `ADDR_PORT_POWER_CONTROL
      |=> {o_group10_gate, o_group9_gate, o_low_groups_gate} == $past(i_wdata[5:3]);
  endproperty
  a_power_write: assert property (p_power_write) else $error("gate outputs wrong");
  property p_sleep_hold;
    (!awake && $stable(i_debug_select_pin))[*4] |-> $stable(o_pad_oe) && $stable(o_pad_ie);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("pad state moved while asleep");
  property p_jtag_dir;
    s_jtag |-> o_pad_oe == 4'h1 && o_pad_ie == 4'he;
  endproperty
  a_jtag_dir: assert property (p_jtag_dir) else $error("jtag pad directions wrong");
  property p_jtag_in;
    s_jtag and s_pins_still |-> {o_jtag_tck, o_jtag_tms, o_jtag_tdi} == i_pad_i[3:1];
  endproperty
  a_jtag_in: assert property (p_jtag_in) else $error("jtag inputs wrong");
  property p_tdo;
    s_jtag |-> o_pad_o[0] == $past(i_jtag_tdo);
  endproperty
  a_tdo: assert property (p_tdo) else $error("test data out wrong");
endmodule

/* verif/pad_pin_model.sv */
`timescale 1ns/1ps
module pad_pin_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // design and far-side drivers
  input wire logic [3:0] i_pad_o,
  input wire logic [3:0] i_pad_oe,
  input wire logic [3:0] i_ext,
  input wire logic [3:0] i_ext_en,
  // pin levels
  output logic [3:0] o_pin
);
  logic [3:0] float_reg;
  // no pulls on these pins, so an undriven pin wanders instead of keeping its level
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      float_reg <= 4'h5;
    else
      float_reg <= ~o_pin;
  end
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      o_pin[i] = i_pad_oe[i] ? i_pad_o[i] : (i_ext_en[i] ? i_ext[i] : float_reg[i]);
  end
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
`include "gpio_group0_cfg.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t mismatch got %h exp %h", $time, g, e); end end
module tb;
  logic i_mclk, i_rst, i_wdt_overflow, i_external_reset_pin, i_sleep, i_deep_sleep, i_wr, i_rd;
  logic i_debug_select_pin, i_jtag_tdo, o_jtag_tdi, o_jtag_tms, o_jtag_tck, o_wake;
  logic o_low_groups_gate, o_group9_gate, o_group10_gate;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  logic [3:0] i_pad_i, o_pad_o, o_pad_oe, o_pad_ie, ext, ext_en;
  int bad_count, tests_run, wakes;
  gpio_group0_jtag_port dut (.*);
  pad_pin_model pins (.i_mclk(i_mclk), .i_rst(i_rst), .i_pad_o(o_pad_o), .i_pad_oe(o_pad_oe),
    .i_ext(ext), .i_ext_en(ext_en), .o_pin(i_pad_i));
  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  ////////////////////////////////////////////////////////////
  // every task except wrap_up starts on a rising edge and ends at the falling edge, where outputs are settled
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(negedge i_mclk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    `CHK(o_rdata, e)
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge i_mclk);
    bad_count++;
    wrap_up;
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    {i_wdt_overflow, i_external_reset_pin, i_sleep, i_deep_sleep, i_wr, i_rd, i_jtag_tdo} = 7'h00;
    i_rst = 1'b1;
    i_debug_select_pin = 1'b1;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    ext = 4'h0;
    ext_en = 4'h0;
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    tick(1);
    `CHK(o_pad_oe | o_pad_ie, 4'h0)
    rd(`ADDR_OUT_ENABLE, 8'h0f);
    rd(`ADDR_IN_ENABLE, 8'h00);
    rd(`ADDR_OUT_DATA, 8'h0f);
    rd(`ADDR_IN_DATA, 8'h00);
    rd(`ADDR_PORT_POWER_CONTROL, 8'h00);
    wr(`ADDR_OUT_ENABLE, 8'hf0);
    rd(`ADDR_OUT_ENABLE, 8'h00);
    `CHK(o_pad_oe, 4'hf)
    wr(`ADDR_OUT_DATA, 8'ha5);
    rd(`ADDR_OUT_DATA, 8'h05);
    `CHK(o_pad_o, 4'h5)
    wr(`ADDR_OUT_ENABLE, 8'h0c);
    wr(`ADDR_IN_ENABLE, 8'h0c);
    @(posedge i_mclk);
    ext <= 4'h8;
    ext_en <= 4'hc;
    tick(4);
    `CHK({o_pad_oe, o_pad_ie}, 8'h3c)
    `CHK(i_pad_i[1:0], 2'h1)
    rd(`ADDR_IN_DATA, 8'h08);
    wr(`ADDR_IN_DATA, 8'hff);
    @(posedge i_mclk);
    ext <= 4'h4;
    tick(4);
    rd(`ADDR_IN_DATA, 8'h04);
    rd(16'h1234, 8'h00);
    wr(`ADDR_IO_WAKE_CONTROL, 8'h02);
    rd(`ADDR_IO_WAKE_CONTROL, 8'h02);
    @(posedge i_mclk);
    i_deep_sleep <= 1'b1;
    wr(`ADDR_OUT_ENABLE, 8'hff);
    rd(`ADDR_OUT_ENABLE, 8'h0c);
    `CHK(o_pad_oe, 4'h3)
    @(posedge i_mclk);
    i_deep_sleep <= 1'b0;
    i_sleep <= 1'b1;
    ext <= 4'h0;
    wakes = 0;
    repeat (10)
    begin
      @(negedge i_mclk);
      wakes += o_wake;
    end
    `CHK(wakes, 1)
    rd(`ADDR_IN_DATA, 8'h04);
    @(posedge i_mclk);
    i_sleep <= 1'b0;
    wr(`ADDR_PORT_POWER_CONTROL, 8'h38);
    rd(`ADDR_PORT_POWER_CONTROL, 8'h38);
    `CHK({o_group10_gate, o_group9_gate, o_low_groups_gate}, 3'h7)
    `CHK(o_pad_oe | o_pad_ie | o_pad_o, 4'h0)
    wr(`ADDR_PORT_POWER_CONTROL, 8'h10);
    `CHK({o_group10_gate, o_group9_gate, o_low_groups_gate}, 3'h2)
    @(posedge i_mclk);
    i_debug_select_pin <= 1'b0;
    ext_en <= 4'he;
    ext <= 4'ha;
    i_jtag_tdo <= 1'b1;
    tick(8);
    `CHK({o_pad_ie, o_pad_oe}, 8'he1)
    `CHK({o_jtag_tck, o_jtag_tms, o_jtag_tdi, o_pad_o[0]}, 4'hb)
    @(posedge i_mclk);
    i_debug_select_pin <= 1'b1;
    ext_en <= 4'hc;
    tick(8);
    @(posedge i_mclk);
    i_wdt_overflow <= 1'b1;
    @(posedge i_mclk);
    i_wdt_overflow <= 1'b0;
    tick(1);
    `CHK(o_pad_oe | o_pad_ie, 4'h0)
    rd(`ADDR_OUT_ENABLE, 8'h0f);
    wr(`ADDR_IN_ENABLE, 8'h03);
    @(posedge i_mclk);
    i_external_reset_pin <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_external_reset_pin <= 1'b0;
    tick(3);
    rd(`ADDR_IN_ENABLE, 8'h00);
    wrap_up;
  end
endmodule
bind gpio_group0_jtag_port gpio_group0_assertions chk (.*);
